//--- hw/rgcal_pkg.sv
// constants shared by the rms gain calibration block
package rgcal_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned SUM_W = DATA_W + CNT_W;
  localparam int unsigned FRAC_SHIFT = 23;
  localparam int unsigned DVD_W = DATA_W + CNT_W + FRAC_SHIFT;
  localparam int unsigned NUM_CH = 4;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_SCALE = 8'h0C;
  localparam logic [7:0] ADDR_SAMPLE_COUNT = 8'h10;
  localparam logic [7:0] ADDR_SETTLE_TIME = 8'h14;
  localparam logic [7:0] ADDR_VOLTAGE_GAIN_ONE = 8'h18;
  localparam logic [7:0] ADDR_VOLTAGE_GAIN_TWO = 8'h1C;
  localparam logic [7:0] ADDR_CURRENT_GAIN_ONE = 8'h20;
  localparam logic [7:0] ADDR_CURRENT_GAIN_TWO = 8'h24;
  localparam logic [7:0] ADDR_PHASE_COMP = 8'h28;

  // control fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_BUSY_BIT = 1;
  localparam int unsigned CTRL_EN_LSB = 4;

  // status / mask fields
  localparam int unsigned ST_W = 5;
  localparam int unsigned ST_DATA_READY_FLAG = 0;
  localparam int unsigned ST_VOLTAGE_ONE_OVERRANGE = 1;
  localparam int unsigned ST_VOLTAGE_TWO_OVERRANGE = 2;
  localparam int unsigned ST_CURRENT_ONE_OVERRANGE = 3;
  localparam int unsigned ST_CURRENT_TWO_OVERRANGE = 4;

  // phase compensation fields, per channel pair
  localparam int unsigned FINE_W = 9;
  localparam int unsigned COARSE_W = 2;
  localparam int unsigned PHASE_CH_W = 16;
  localparam int unsigned FINE_STEPS_PER_SAMPLE = 512;

  // reset values and targets
  localparam logic [DATA_W-1:0] GAIN_ONE = 24'h400000;
  localparam logic [DATA_W-1:0] SCALE_RST = 24'h4CCCCC;
  localparam logic [DATA_W-1:0] VOLT_TARGET = 24'h4CCCCC;
  localparam logic [CNT_W-1:0] SAMPLE_COUNT_RST = 16'h0FA0;
  localparam logic [CNT_W-1:0] SETTLE_TIME_RST = 16'h0FA0;

  typedef enum logic [2:0] {
    RGCAL_IDLE,
    RGCAL_SETTLE,
    RGCAL_ACCUM,
    RGCAL_PICK,
    RGCAL_DIVIDE,
    RGCAL_STORE
  } rgcal_state_e;
endpackage

//--- hw/rgcal_core.sv
// rms gain calibration engine with wishbone register file
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - voltage gain becomes 0.6 divided by the averaged voltage rms result.
// - current gain becomes scale over the averaged current rms result.
// - gain of four or more is invalid and is never stored.
// - overflow in calibration or normal running sets channel overrange bit.
// - scale register resets to 0.6.
// - coarse delay for over one sample or voltage delay, else fine only.
// - fine step is 1/512 sample: 0.008789 deg at 50 Hz, 4000 Hz rate.
// - average N samples after settle samples, then set data ready.
// - gains are unsigned 2.22 values below 4.0, reset to 1.0.
module rgcal_core
  import rgcal_pkg::*;
#(
  parameter int unsigned CW = rgcal_pkg::CNT_W
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic owr_tick_i,
  input wire logic [rgcal_pkg::DATA_W-1:0] voltage_one_rms_result_i,
  input wire logic [rgcal_pkg::DATA_W-1:0] voltage_two_rms_result_i,
  input wire logic [rgcal_pkg::DATA_W-1:0] current_one_rms_result_i,
  input wire logic [rgcal_pkg::DATA_W-1:0] current_two_rms_result_i,
  input wire logic [rgcal_pkg::NUM_CH-1:0] overflow_i,
  output logic [rgcal_pkg::DATA_W-1:0] voltage_gain_one_o,
  output logic [rgcal_pkg::DATA_W-1:0] voltage_gain_two_o,
  output logic [rgcal_pkg::DATA_W-1:0] current_gain_one_o,
  output logic [rgcal_pkg::DATA_W-1:0] current_gain_two_o,
  output logic [rgcal_pkg::COARSE_W-1:0] coarse_phase_delay_one_o,
  output logic [rgcal_pkg::COARSE_W-1:0] coarse_phase_delay_two_o,
  output logic [rgcal_pkg::FINE_W-1:0] fine_phase_delay_one_o,
  output logic [rgcal_pkg::FINE_W-1:0] fine_phase_delay_two_o,
  output logic cal_busy_o,
  output logic irq_o
);
  import rgcal_pkg::*;

  rgcal_state_e state_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [NUM_CH-1:0] chan_en_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [DATA_W-1:0] scale_q;
  logic [CNT_W-1:0] sample_count_q;
  logic [CNT_W-1:0] settle_time_q;
  logic [DATA_W-1:0] gain_q [NUM_CH];
  logic [2*PHASE_CH_W-1:0] phase_comp_reg_q;
  logic [CNT_W-1:0] cnt_q;
  logic [SUM_W-1:0] sum_q [NUM_CH];
  logic [1:0] ch_q;
  logic [SUM_W:0] rem_q;
  logic [DVD_W-1:0] dvd_q;
  logic [DVD_W-1:0] quo_q;
  logic [6:0] step_q;
  logic [DATA_W-1:0] rms [NUM_CH];
  logic wb_req;
  logic wr_en;
  logic start_req;
  logic cal_done;
  logic [ST_W-1:0] or_event;
  logic [SUM_W:0] trial;
  logic quo_bad;

  // byte-lane merge of a bus write into a register's old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // voltage channels aim at a fixed 0.6, current channels at scale
  function automatic logic [DATA_W-1:0] cal_target(
    input logic [1:0] ch,
    input logic [DATA_W-1:0] sc);
    if (ch < 2'd2)
    begin
      return VOLT_TARGET;
    end
    return sc;
  endfunction

  assign rms[0] = voltage_one_rms_result_i;
  assign rms[1] = voltage_two_rms_result_i;
  assign rms[2] = current_one_rms_result_i;
  assign rms[3] = current_two_rms_result_i;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_en = ce_i & wb_req & wb_we_i;
  assign start_req = wr_en & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0]
                     & wb_dat_i[CTRL_START_BIT] & (state_q == RGCAL_IDLE);

  // bus handshake: answer one cycle after the request, every address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_q <= wb_req;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (ce_i && wb_req)
    begin
      case (wb_adr_i)
        ADDR_CTRL: rdata_q <= 32'({chan_en_q, 2'b00,
                                   cal_busy_o, 1'b0});
        ADDR_STATUS: rdata_q <= 32'(status_q);
        ADDR_MASK: rdata_q <= 32'(mask_q);
        ADDR_SCALE: rdata_q <= 32'(scale_q);
        ADDR_SAMPLE_COUNT: rdata_q <= 32'(sample_count_q);
        ADDR_SETTLE_TIME: rdata_q <= 32'(settle_time_q);
        ADDR_VOLTAGE_GAIN_ONE: rdata_q <= 32'(gain_q[0]);
        ADDR_VOLTAGE_GAIN_TWO: rdata_q <= 32'(gain_q[1]);
        ADDR_CURRENT_GAIN_ONE: rdata_q <= 32'(gain_q[2]);
        ADDR_CURRENT_GAIN_TWO: rdata_q <= 32'(gain_q[3]);
        ADDR_PHASE_COMP: rdata_q <= phase_comp_reg_q;
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // plain configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chan_en_q <= '0;
      mask_q <= '0;
      scale_q <= SCALE_RST;
      sample_count_q <= SAMPLE_COUNT_RST;
      settle_time_q <= SETTLE_TIME_RST;
      phase_comp_reg_q <= '0;
    end
    else if (wr_en)
    begin
      case (wb_adr_i)
        ADDR_CTRL:
        begin
          if (wb_sel_i[0] && state_q == RGCAL_IDLE)
          begin
            chan_en_q <= wb_dat_i[CTRL_EN_LSB +: NUM_CH];
          end
        end
        ADDR_MASK: mask_q <= ST_W'(merge(32'(mask_q), wb_dat_i, wb_sel_i));
        ADDR_SCALE: scale_q <= DATA_W'(merge(32'(scale_q), wb_dat_i,
                                             wb_sel_i));
        ADDR_SAMPLE_COUNT: sample_count_q <= CNT_W'(merge(32'(sample_count_q),
          wb_dat_i, wb_sel_i));
        ADDR_SETTLE_TIME: settle_time_q <= CNT_W'(merge(32'(settle_time_q),
          wb_dat_i, wb_sel_i));
        // coarse is meant for over one sample or voltage-side delay
        ADDR_PHASE_COMP: phase_comp_reg_q <= merge(phase_comp_reg_q,
                                                   wb_dat_i,
                                                   wb_sel_i);
        default:
        begin
        end
      endcase
    end
  end

  // one fine step is 1/512 of an output word: 4.5 deg at 50 Hz / 512
  assign fine_phase_delay_one_o = phase_comp_reg_q[FINE_W-1:0];
  assign fine_phase_delay_two_o =
    phase_comp_reg_q[PHASE_CH_W +: FINE_W];
  assign coarse_phase_delay_one_o =
    phase_comp_reg_q[FINE_W +: COARSE_W];
  assign coarse_phase_delay_two_o =
    phase_comp_reg_q[PHASE_CH_W+FINE_W +: COARSE_W];

  // calibration sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= RGCAL_IDLE;
      cnt_q <= '0;
      ch_q <= 2'd0;
    end
    else if (ce_i)
    begin
      case (state_q)
        RGCAL_IDLE:
        begin
          if (start_req)
          begin
            state_q <= RGCAL_SETTLE;
            cnt_q <= '0;
          end
        end
        RGCAL_SETTLE:
        begin
          if (cnt_q >= settle_time_q)
          begin
            state_q <= RGCAL_ACCUM;
            cnt_q <= '0;
          end
          else if (owr_tick_i)
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        RGCAL_ACCUM:
        begin
          if (cnt_q >= sample_count_q)
          begin
            state_q <= RGCAL_PICK;
            ch_q <= 2'd0;
          end
          else if (owr_tick_i)
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        RGCAL_PICK:
        begin
          if (chan_en_q[ch_q])
          begin
            state_q <= RGCAL_DIVIDE;
          end
          else if (ch_q == 2'd3)
          begin
            state_q <= RGCAL_IDLE;
          end
          else
          begin
            ch_q <= ch_q + 1'b1;
          end
        end
        RGCAL_DIVIDE:
        begin
          if (step_q == 7'(DVD_W))
          begin
            state_q <= RGCAL_STORE;
          end
        end
        RGCAL_STORE:
        begin
          if (ch_q == 2'd3)
          begin
            state_q <= RGCAL_IDLE;
          end
          else
          begin
            ch_q <= ch_q + 1'b1;
            state_q <= RGCAL_PICK;
          end
        end
        default: state_q <= RGCAL_IDLE;
      endcase
    end
  end

  assign cal_busy_o = (state_q != RGCAL_IDLE);
  assign cal_done = ce_i & (((state_q == RGCAL_STORE) && ch_q == 2'd3)
                    || (state_q == RGCAL_PICK && !chan_en_q[ch_q]
                        && ch_q == 2'd3));

  // sums of N rms results per channel; N=0 leaves a zero sum
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        sum_q[c] <= '0;
      end
    end
    else if (ce_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (start_req)
        begin
          sum_q[c] <= '0;
        end
        else if (state_q == RGCAL_ACCUM && owr_tick_i
                 && cnt_q < sample_count_q)
        begin
          sum_q[c] <= sum_q[c] + SUM_W'(rms[c]);
        end
      end
    end
  end

  // gain = target * N * 2^23 / sum, one quotient bit per clock;
  // slow but needs no multiplier-sized divider
  assign trial = {rem_q[SUM_W-1:0], dvd_q[DVD_W-1]};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rem_q <= '0;
      dvd_q <= '0;
      quo_q <= '0;
      step_q <= '0;
    end
    else if (ce_i)
    begin
      if (state_q == RGCAL_PICK)
      begin
        rem_q <= '0;
        // widen first: inside a concatenation the product is self-sized
        dvd_q <= {SUM_W'(cal_target(ch_q, scale_q)) * SUM_W'(sample_count_q),
                  FRAC_SHIFT'(0)};
        quo_q <= '0;
        step_q <= '0;
      end
      else if (state_q == RGCAL_DIVIDE && step_q != 7'(DVD_W))
      begin
        if (trial >= {1'b0, sum_q[ch_q]})
        begin
          rem_q <= trial - {1'b0, sum_q[ch_q]};
          quo_q <= {quo_q[DVD_W-2:0], 1'b1};
        end
        else
        begin
          rem_q <= trial;
          quo_q <= {quo_q[DVD_W-2:0], 1'b0};
        end
        dvd_q <= {dvd_q[DVD_W-2:0], 1'b0};
        step_q <= step_q + 1'b1;
      end
    end
  end

  // 2.22 format tops out below four; a zero sum is no result either
  assign quo_bad = (quo_q[DVD_W-1:DATA_W] != '0)
                   || (sum_q[ch_q] == '0);

  // gain registers: host writes, calibration overwrites on success
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        gain_q[c] <= GAIN_ONE;
      end
    end
    else if (ce_i)
    begin
      if (state_q == RGCAL_STORE && !quo_bad)
      begin
        gain_q[ch_q] <= quo_q[DATA_W-1:0];
      end
      else if (wr_en)
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          if (wb_adr_i == ADDR_VOLTAGE_GAIN_ONE + 8'(4 * c))
          begin
            gain_q[c] <= DATA_W'(merge(32'(gain_q[c]), wb_dat_i,
                                       wb_sel_i));
          end
        end
      end
    end
  end

  assign voltage_gain_one_o = gain_q[0];
  assign voltage_gain_two_o = gain_q[1];
  assign current_gain_one_o = gain_q[2];
  assign current_gain_two_o = gain_q[3];

  // overrange from a bad quotient or from the datapath at any time
  always_comb
  begin
    or_event = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (overflow_i[c]
          || (state_q == RGCAL_STORE && quo_bad && ch_q == 2'(c)))
      begin
        or_event[ST_VOLTAGE_ONE_OVERRANGE + c] = 1'b1;
      end
    end
    or_event[ST_DATA_READY_FLAG] = cal_done;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_q <= '0;
    end
    else if (ce_i)
    begin
      if (wr_en && wb_adr_i == ADDR_STATUS && wb_sel_i[0])
      begin
        status_q <= (status_q & ~wb_dat_i[ST_W-1:0]) | or_event;
      end
      else
      begin
        status_q <= status_q | or_event;
      end
    end
  end

  assign irq_o = |(status_q & mask_q);
endmodule

//--- tb/rgcal_core_checker.sv
// port-level checks on the rms gain calibration block
`timescale 1ns/1ps
module rgcal_core_checker
  import rgcal_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [rgcal_pkg::DATA_W-1:0] voltage_gain_one_o,
  input wire logic [rgcal_pkg::COARSE_W-1:0] coarse_phase_delay_one_o,
  input wire logic [rgcal_pkg::FINE_W-1:0] fine_phase_delay_one_o,
  input wire logic cal_busy_o,
  input wire logic irq_o
);
  logic req;
  // a request is taken only while ack is low and the clock is enabled
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_once; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_rst_vals;
    $fell(rst_i) |-> voltage_gain_one_o == GAIN_ONE && !cal_busy_o && !irq_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("reset value");
  property p_start;
    req && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[0]
      && !cal_busy_o |=> cal_busy_o;
  endproperty
  a_start: assert property (p_start) else $error("start lost");
  property p_busy_read;
    req && !wb_we_i && wb_adr_i == ADDR_CTRL
      |=> wb_dat_o[CTRL_BUSY_BIT] == $past(cal_busy_o);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit");
  property p_unmapped;
    req && !wb_we_i && wb_adr_i > 8'h2B |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_phase_wr;
    req && wb_we_i && wb_adr_i == ADDR_PHASE_COMP && wb_sel_i[1:0] == 2'h3
      |=> {coarse_phase_delay_one_o, fine_phase_delay_one_o}
        == 11'($past(wb_dat_i));
  endproperty
  a_phase_wr: assert property (p_phase_wr)
    else $error("phase");
  property p_gain_wr;
    req && wb_we_i && wb_adr_i == ADDR_VOLTAGE_GAIN_ONE
      && wb_sel_i[2:0] == 3'h7 && !cal_busy_o
      |=> voltage_gain_one_o == 24'($past(wb_dat_i));
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain write");
  // outside a run only the host may move a gain
  property p_gain_hold;
    !cal_busy_o && !(req && wb_we_i) |=> $stable(voltage_gain_one_o);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("gain moved");
endmodule

bind rgcal_core rgcal_core_checker u_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .voltage_gain_one_o, .coarse_phase_delay_one_o, .fine_phase_delay_one_o,
  .cal_busy_o, .irq_o);

//--- tb/rgcal_rms_src.sv
// reference-signal front end: one rms word per output word tick
`timescale 1ns/1ps
module rgcal_rms_src
  import rgcal_pkg::*;
#(
  parameter int unsigned PERIOD = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4*rgcal_pkg::DATA_W-1:0] ref_i,
  output logic tick_o,
  output logic [4*rgcal_pkg::DATA_W-1:0] rms_o
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cnt_q == 8'(PERIOD - 1))
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end
  assign tick_o = !rst_i && cnt_q == 8'(PERIOD - 1);
  // word is valid only in the tick cycle; stale otherwise, so inverted
  assign rms_o = tick_o ? ref_i : ~ref_i;
endmodule

//--- tb/tb_top.sv
// self-checking bench for the rms gain calibration block
`timescale 1ns/1ps
module tb_top;
  import rgcal_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] ovf = 4'h0;
  logic ce = 1'b1;
  logic [95:0] ref_v = {4{24'h400000}};
  logic [95:0] rms;
  logic tick, ack, busy, irq;
  logic [31:0] rd, dat_o, e, st, d;
  logic [23:0] g [4];
  logic [23:0] r [4];
  logic [23:0] sc;
  logic [1:0] c1, c2;
  logic [8:0] f1, f2;
  logic [7:0] ga [4] = '{ADDR_VOLTAGE_GAIN_ONE, ADDR_VOLTAGE_GAIN_TWO,
    ADDR_CURRENT_GAIN_ONE, ADDR_CURRENT_GAIN_TWO};
  int checks = 0;
  int err_total = 0;
  int cyc_n = 0;
  int n;
  integer seed = 32'h2CA8;

  rgcal_rms_src #(.PERIOD(8)) u_rgcal_rms_src (.clk_i(clk_i), .rst_i(rst_i),
    .ref_i(ref_v), .tick_o(tick), .rms_o(rms));
  rgcal_core u_rgcal_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .owr_tick_i(tick), .voltage_one_rms_result_i(rms[95:72]),
    .voltage_two_rms_result_i(rms[71:48]),
    .current_one_rms_result_i(rms[47:24]),
    .current_two_rms_result_i(rms[23:0]), .overflow_i(ovf),
    .voltage_gain_one_o(g[0]), .voltage_gain_two_o(g[1]),
    .current_gain_one_o(g[2]), .current_gain_two_o(g[3]),
    .coarse_phase_delay_one_o(c1), .coarse_phase_delay_two_o(c2),
    .fine_phase_delay_one_o(f1), .fine_phase_delay_two_o(f2),
    .cal_busy_o(busy), .irq_o(irq));

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a hung handshake ends up here
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // expected gain, bit 24 flags a quotient of four or more
  function automatic logic [31:0] exp_gain(input logic [23:0] t, v);
    logic [47:0] q;
    q = {1'b0, t, 23'h0} / {24'h0, v};
    return (q > 48'hFFFFFF) ? 32'h1000000 : {8'h0, q[23:0]};
  endfunction

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_SCALE, 32'h0);
    chk(rd, {8'h0, SCALE_RST});
    for (int c = 0; c < 4; c++)
      chk({8'h0, g[c]}, {8'h0, GAIN_ONE});
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // settle long enough that skipping it shows in the tick count
    wb(1'b1, ADDR_SETTLE_TIME, 32'h28);
    // offset and temperature steps stay with the host, outside this block
    wb(1'b1, ADDR_SAMPLE_COUNT, 32'h4);
    wb(1'b1, ADDR_MASK, 32'h1F);
    for (int k = 0; k < 4; k++)
    begin
      sc = 24'h200000 + 24'($random(seed) & 32'h1FFFFF);
      wb(1'b1, ADDR_SCALE, {8'h0, sc});
      for (int c = 0; c < 4; c++)
      begin
        r[c] = 24'h300000 + 24'($random(seed) & 32'h1FFFFF);
        wb(1'b1, ga[c], {8'h0, GAIN_ONE});
      end
      // last run: gain past four on one channel, full-scale rms on another
      if (k == 3)
      begin
        r[0] = 24'h100000;
        r[3] = 24'hFFFFFF;
      end
      ref_v <= {r[0], r[1], r[2], r[3]};
      wb(1'b1, ADDR_CTRL, 32'hF1);
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk({31'h0, rd[CTRL_BUSY_BIT]}, 32'h1);
      n = 0;
      // an overrange bit may raise irq early, so wait for the whole run
      while (busy !== 1'b0)
      begin
        @(posedge clk_i);
        if (tick === 1'b1)
          n++;
      end
      chk({31'h0, n >= 44}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      st = 32'h1;
      for (int c = 0; c < 4; c++)
      begin
        e = exp_gain(c < 2 ? VOLT_TARGET : sc, r[c]);
        if (e[24])
          st[c + 1] = 1'b1;
        wb(1'b0, ga[c], 32'h0);
        chk(rd, e[24] ? {8'h0, GAIN_ONE} : e);
      end
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, st);
      wb(1'b1, ADDR_STATUS, 32'h1F);
      chk({31'h0, irq}, 32'h0);
    end
    wb(1'b1, ADDR_MASK, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_i);
      ovf <= 4'(1 << c);
      @(posedge clk_i);
      ovf <= 4'h0;
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'(2 << c));
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, ADDR_MASK, 32'(2 << c));
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, ADDR_STATUS, 32'h1F);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, ADDR_MASK, 32'h0);
    end
    for (int k = 0; k < 3; k++)
    begin
      d = (k == 0) ? 32'h07FF07FF : ($random(seed) & 32'h07FF07FF);
      wb(1'b1, ADDR_PHASE_COMP, d);
      chk({5'h0, c2, f2, 5'h0, c1, f1}, d);
      wb(1'b0, ADDR_PHASE_COMP, 32'h0);
      chk(rd, d);
    end
    // a frozen clock enable must drop an overflow pulse
    @(posedge clk_i);
    ce <= 1'b0;
    ovf <= 4'hF;
    @(posedge clk_i);
    ovf <= 4'h0;
    ce <= 1'b1;
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule
